// ### logic/spc_pkg.sv
// constants and carrier types of the clock prescaler and sleep controller
package spc_pkg;
  // register map (word index on the plain register port)
  localparam logic [7:0] SPC_ADDR_DIV   = 8'h00;
  localparam logic [7:0] SPC_ADDR_SLEEP = 8'h01;
  // clock divider control fields
  localparam int         SPC_UNLOCK_BIT = 7;
  localparam logic [7:0] SPC_UNLOCK_VAL = 8'h80;
  localparam int         SPC_SEL_LSB    = 0;
  localparam int         SPC_SEL_W      = 4;
  localparam logic [3:0] SPC_SEL_MAX    = 4'h8;
  localparam logic [3:0] SPC_SEL_RST    = 4'h0;
  localparam logic [3:0] SPC_SEL_RST_D8 = 4'h3;
  // sleep control fields
  localparam int         SPC_ALLOW_BIT  = 5;
  localparam int         SPC_KIND_LSB   = 3;
  // timing counts
  localparam logic [1:0] SPC_UNLOCK_TICKS = 2'h3;  // last of four divided cycles
  localparam int         SPC_WAKE_EXTRA   = 4;
  localparam logic [1:0] SPC_FUSE_SETTLE  = 2'h2;
  localparam int         SPC_CNT_W        = 8;

  typedef enum logic [1:0] {
    SPC_KIND_IDLE    = 2'h0,
    SPC_KIND_ADC_NR  = 2'h1,
    SPC_KIND_PWR_DN  = 2'h2,
    SPC_KIND_STANDBY = 2'h3
  } spc_kind_t;

  typedef struct packed {
    logic any_irq;
    logic adc_done;
    logic mem_ready;
    logic ext0_irq;
    logic ext0_level;
    logic pin_change;
    logic wdt_irq;
  } spc_wake_t;

  typedef struct packed {
    logic core_clock_domain;
    logic program_memory_clock_domain;
    logic peripheral_io_clock_domain;
    logic converter_clock_domain;
    logic fast_peripheral_clock_domain;
    logic main_osc;
  } spc_gate_t;
endpackage : spc_pkg

// ### logic/spc_top.sv
// clock prescaler with unlock sequence and sleep mode clock gating
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spc_top
  import spc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 6
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // fuse strap, from a pin
  input  wire logic       divide_by_eight_fuse,
  // core side
  input  wire logic       sleep_instr,
  input  wire logic       adc_enabled,
  input  wire spc_wake_t  wake_src,
  output logic            sys_tick,
  output logic            adc_start,
  output logic            core_resume,
  output logic            sleeping,
  output var spc_gate_t   gates
);

  // halt counter is eight bits wide, so longer start-ups cannot be served
  if (STARTUP_CYCLES < 0 || STARTUP_CYCLES + SPC_WAKE_EXTRA > 255) begin : g_bad_startup
    $error("spc_top: STARTUP_CYCLES out of range");
  end

  localparam logic [7:0] WAKE_LAST = 8'(STARTUP_CYCLES + SPC_WAKE_EXTRA - 1);

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} spc_state_t;

  // fuse strap synchroniser and settle counter
  logic       fuse_s1_reg;
  logic       fuse_s2_reg;
  logic [1:0] init_cnt_reg;
  logic       init_done_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_s1_reg <= 1'b0;
      fuse_s2_reg <= 1'b0;
    end else begin
      fuse_s1_reg <= divide_by_eight_fuse;
      fuse_s2_reg <= fuse_s1_reg;
    end
  end

  // strap is caught after release, once the synchroniser has settled
  logic init_load;
  assign init_load = !init_done_reg && (init_cnt_reg == SPC_FUSE_SETTLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_reg  <= 2'h0;
      init_done_reg <= 1'b0;
    end else if (!init_done_reg) begin
      init_cnt_reg  <= init_cnt_reg + 2'h1;
      init_done_reg <= init_load;
    end
  end

  // register decode
  logic wr_div;
  logic wr_sleep;
  logic wr_unlock_pat;
  logic wr_select;
  assign wr_div        = reg_wr && (reg_addr == SPC_ADDR_DIV);
  assign wr_sleep      = reg_wr && (reg_addr == SPC_ADDR_SLEEP);
  assign wr_unlock_pat = wr_div && (reg_wdata == SPC_UNLOCK_VAL);
  assign wr_select     = wr_div && !reg_wdata[SPC_UNLOCK_BIT];

  // divider state
  logic [3:0]           sel_reg;      // programmed select, as read back
  logic [3:0]           sel_act_reg;  // select the counter is running on
  logic                 switch_pend_reg;
  logic [SPC_CNT_W-1:0] cnt_reg;
  logic [SPC_CNT_W-1:0] cnt_mask;
  logic                 tick;
  logic                 unlock_reg;
  logic [1:0]           ucnt_reg;

  assign cnt_mask = SPC_CNT_W'((9'h1 << sel_act_reg) - 9'h1);
  assign tick     = init_done_reg && ((cnt_reg & cnt_mask) == cnt_mask);

  // reserved select codes are ignored so the factor never leaves 1..256
  logic sel_accept;
  assign sel_accept = wr_select && unlock_reg
                      && (reg_wdata[SPC_SEL_LSB +: SPC_SEL_W] <= SPC_SEL_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= SPC_SEL_RST;
    end else if (init_load) begin
      sel_reg <= fuse_s2_reg ? SPC_SEL_RST_D8 : SPC_SEL_RST;
    end else if (sel_accept) begin
      sel_reg <= reg_wdata[SPC_SEL_LSB +: SPC_SEL_W];
    end
  end

  // a new factor waits for the running period to end, then restarts at zero:
  // no period is cut short and two edges span the change
  logic switch_now;
  assign switch_now = switch_pend_reg && tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_act_reg     <= SPC_SEL_RST;
      switch_pend_reg <= 1'b0;
      cnt_reg         <= '0;
    end else begin
      if (init_load) begin
        sel_act_reg <= fuse_s2_reg ? SPC_SEL_RST_D8 : SPC_SEL_RST;
      end else if (switch_now) begin
        sel_act_reg <= sel_reg;
      end
      switch_pend_reg <= sel_accept || (switch_pend_reg && !tick);
      cnt_reg         <= (switch_now || !init_done_reg) ? '0 : cnt_reg + 1'b1;
    end
  end

  // unlock window, counted in divided cycles after the unlocking write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_reg <= 1'b0;
      ucnt_reg   <= 2'h0;
    end else if (!unlock_reg) begin
      unlock_reg <= wr_unlock_pat;
      ucnt_reg   <= 2'h0;
    end else if (wr_select) begin
      unlock_reg <= 1'b0;
    end else if (tick) begin
      unlock_reg <= (ucnt_reg != SPC_UNLOCK_TICKS);
      ucnt_reg   <= ucnt_reg + 2'h1;
    end
  end

  // sleep control
  logic      allow_reg;
  spc_kind_t kind_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      allow_reg <= 1'b0;
      kind_reg  <= SPC_KIND_IDLE;
    end else if (wr_sleep) begin
      allow_reg <= reg_wdata[SPC_ALLOW_BIT];
      kind_reg  <= spc_kind_t'(reg_wdata[SPC_KIND_LSB +: 2]);
    end
  end

  // wake qualification per sleep kind
  logic line0_deep;
  logic wake_adc_nr;
  logic wake_deep;
  logic wake_hit;
  assign line0_deep  = wake_src.ext0_irq && wake_src.ext0_level;
  assign wake_deep   = line0_deep || wake_src.pin_change || wake_src.wdt_irq;
  assign wake_adc_nr = wake_deep || wake_src.adc_done || wake_src.mem_ready;

  always_comb begin
    case (kind_reg)
      SPC_KIND_IDLE:   wake_hit = wake_src.any_irq;
      SPC_KIND_ADC_NR: wake_hit = wake_adc_nr;
      default:         wake_hit = wake_deep;
    endcase
  end

  // sleep sequencer; an asynchronous reset returns straight to active
  spc_state_t state_reg;
  spc_state_t state_next;
  logic [7:0] wcnt_reg;
  logic       enter_sleep;
  logic       wake_done;

  assign enter_sleep = (state_reg == ST_ACTIVE) && sleep_instr && allow_reg;
  assign wake_done   = (state_reg == ST_WAKE) && tick && (wcnt_reg == WAKE_LAST);

  always_comb begin
    case (state_reg)
      ST_ACTIVE: state_next = enter_sleep ? ST_SLEEP : ST_ACTIVE;
      ST_SLEEP:  state_next = wake_hit ? ST_WAKE : ST_SLEEP;
      ST_WAKE:   state_next = wake_done ? ST_ACTIVE : ST_WAKE;
      default:   state_next = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // halt counter runs on divided ticks so the four extra are core cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_reg <= 8'h00;
    end else if (state_reg != ST_WAKE) begin
      wcnt_reg <= 8'h00;
    end else if (tick) begin
      wcnt_reg <= wcnt_reg + 8'h01;
    end
  end

  // clock domain gating; register file and memory keep state as the core
  // clock only stops
  logic      in_sleep;
  logic      io_stop;
  logic      adc_stop;
  logic      osc_stop;
  spc_gate_t gates_next;
  assign in_sleep = (state_reg == ST_SLEEP);
  assign io_stop  = in_sleep && (kind_reg != SPC_KIND_IDLE);
  assign adc_stop = in_sleep && (kind_reg[1] == 1'b1);
  assign osc_stop = in_sleep && (kind_reg == SPC_KIND_PWR_DN);

  // standby keeps the oscillator so it wakes without a restart
  always_comb begin
    gates_next.core_clock_domain            = tick && (state_reg == ST_ACTIVE);
    gates_next.program_memory_clock_domain  = tick && (state_reg == ST_ACTIVE);
    gates_next.peripheral_io_clock_domain   = tick && !io_stop;
    gates_next.converter_clock_domain       = tick && !adc_stop;
    gates_next.fast_peripheral_clock_domain = !io_stop;
    gates_next.main_osc                     = !osc_stop;
  end

  logic adc_kick;
  assign adc_kick = enter_sleep && adc_enabled && (kind_reg[1] == 1'b0);

  // read mux
  logic [7:0] rd_div;
  logic [7:0] rd_sleep;
  logic [7:0] rd_mux;
  assign rd_div   = {unlock_reg, 3'b000, sel_reg};
  assign rd_sleep = {2'b00, allow_reg, kind_reg, 3'b000};
  assign rd_mux   = (reg_addr == SPC_ADDR_DIV)   ? rd_div   :
                    (reg_addr == SPC_ADDR_SLEEP) ? rd_sleep : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata   <= 8'h00;
      gates       <= '0;
      sys_tick    <= 1'b0;
      adc_start   <= 1'b0;
      core_resume <= 1'b0;
      sleeping    <= 1'b0;
    end else begin
      reg_rdata   <= reg_rd ? rd_mux : 8'h00;
      gates       <= gates_next;
      sys_tick    <= tick;
      adc_start   <= adc_kick;
      core_resume <= wake_done;
      sleeping    <= (state_next != ST_ACTIVE);
    end
  end

endmodule : spc_top
`default_nettype wire

// ### bench/spc_checker.sv
// port-level assertions for the prescaler and sleep controller
`timescale 1ns/1ps
`default_nettype none
module spc_checker
  import spc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 6
) (
  // clock, reset, register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic       sleep_instr,
  input wire logic       adc_enabled,
  input wire logic       adc_start,
  input wire logic       core_resume,
  input wire logic       sleeping,
  input wire spc_gate_t  gates
);
  // shadow of the sleep control fields, as last written
  logic       allow_q;
  logic [1:0] kind_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      allow_q <= 1'b0;
      kind_q  <= 2'h0;
    end else if (reg_wr && reg_addr == SPC_ADDR_SLEEP) begin
      allow_q <= reg_wdata[SPC_ALLOW_BIT];
      kind_q  <= reg_wdata[SPC_KIND_LSB +: 2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_div_res; reg_rd && reg_addr == SPC_ADDR_DIV |=> reg_rdata[6:4] == 3'h0; endproperty
  property p_slp_res; reg_rd && reg_addr == SPC_ADDR_SLEEP |=> !reg_rdata[2]; endproperty
  property p_allow; $rose(sleeping) |-> $past(sleep_instr && allow_q); endproperty
  property p_adc; $rose(sleeping) && !kind_q[1] && adc_enabled |-> ##[0:1] adc_start; endproperty
  property p_pd; $rose(sleeping) && kind_q == SPC_KIND_PWR_DN |-> ##[0:2] !gates.main_osc; endproperty
  property p_idle;
    $rose(sleeping) && kind_q == SPC_KIND_IDLE
      |-> ##2 !gates.core_clock_domain && gates.fast_peripheral_clock_domain;
  endproperty
  property p_adcnr;
    $rose(sleeping) && kind_q == SPC_KIND_ADC_NR
      |-> ##2 !gates.peripheral_io_clock_domain && !gates.fast_peripheral_clock_domain;
  endproperty
  property p_resume; core_resume |-> $past(sleeping); endproperty
  a_div_res: assert property (p_div_res) else $error("divider reserved bits set");
  a_slp_res: assert property (p_slp_res) else $error("sleep bit 2 set");
  a_allow: assert property (p_allow) else $error("sleep without allow");
  a_adc: assert property (p_adc) else $error("no converter start");
  a_pd: assert property (p_pd) else $error("oscillator on in power-down");
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  a_adcnr: assert property (p_adcnr) else $error("noise mode gating wrong");
  a_resume: assert property (p_resume) else $error("resume outside sleep");
  c_sleep: cover property ($rose(sleeping));
  c_adc: cover property (adc_start);
  c_resume: cover property (core_resume);
endmodule : spc_checker
bind spc_top spc_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_instr(sleep_instr), .adc_enabled(adc_enabled), .adc_start(adc_start),
  .core_resume(core_resume), .sleeping(sleeping), .gates(gates)
);
`default_nettype wire

// ### bench/test_sysclk_prescaler_sleep_ctrl.sv
// self-checking bench for the prescaler and sleep controller
`timescale 1ns/1ps
`default_nettype none
module test_sysclk_prescaler_sleep_ctrl
  import spc_pkg::*;
;
  localparam int SC = 4;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       fuse = 1'b0;
  logic       sleep_instr = 1'b0;
  logic       adc_en = 1'b0;
  spc_wake_t  wake = '0;
  logic [7:0] reg_rdata;
  logic       sys_tick;
  logic       adc_start;
  logic       core_resume;
  logic       sleeping;
  spc_gate_t  gates;
  logic [7:0] d;
  int         mismatches = 0;
  int         checks_done = 0;
  int         c1;
  int         c2;
  always #25 clk = ~clk;
  spc_top #(.STARTUP_CYCLES(SC)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .divide_by_eight_fuse(fuse), .sleep_instr(sleep_instr), .adc_enabled(adc_en),
    .wake_src(wake), .sys_tick(sys_tick), .adc_start(adc_start),
    .core_resume(core_resume), .sleeping(sleeping), .gates(gates)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // bounded wait for the next divided tick
  task automatic tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sys_tick !== 1'b1 && n < 2000);
  endtask : tick
  task automatic do_reset(input logic f);
    rst_n <= 1'b0;
    fuse <= f;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  task automatic slp;
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask : slp
  task automatic pulse_wake(input logic [6:0] w);
    @(posedge clk);
    wake <= spc_wake_t'(w);
    @(posedge clk);
    wake <= '0;
  endtask : pulse_wake
  task automatic setsel(input int s, input int po);
    int pn;
    pn = 1 << s;
    wr(SPC_ADDR_DIV, SPC_UNLOCK_VAL);
    wr(SPC_ADDR_DIV, 8'(s));
    tick(c1);
    tick(c2);
    chk(c1 + c2 <= po + 2 * pn + 1, 1);
    chk(c2 >= (po < pn ? po : pn), 1);
    tick(c1);
    chk(16'(c1), 16'(pn));
    rd(SPC_ADDR_DIV);
    chk(d, 8'(s));
  endtask : setsel
  task automatic t_fuse;
    do_reset(1'b1);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h03);
    tick(c1);
    tick(c1);
    chk(16'(c1), 16'h8);
    do_reset(1'b0);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h00);
    for (int s = 0; s <= 8; s++) setsel(s, s == 0 ? 1 : 1 << (s - 1));
    $display("factor test done");
  endtask : t_fuse
  // runs at factor 256 so each window spans many master cycles
  task automatic t_unlock;
    wr(SPC_ADDR_DIV, 8'h81);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h08);
    wr(SPC_ADDR_DIV, SPC_UNLOCK_VAL);
    tick(c1);
    tick(c1);
    wr(SPC_ADDR_DIV, SPC_UNLOCK_VAL);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h88);
    tick(c1);
    tick(c1);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h08);
    wr(SPC_ADDR_DIV, 8'h00);
    wr(SPC_ADDR_DIV, SPC_UNLOCK_VAL);
    wr(SPC_ADDR_DIV, 8'h09);
    wr(SPC_ADDR_DIV, 8'h00);
    rd(SPC_ADDR_DIV);
    chk(d, 8'h08);
    setsel(0, 256);
    $display("unlock test done");
  endtask : t_unlock
  task automatic t_sleep;
    logic [6:0] neg [4] = '{7'h00, 7'h40, 7'h08, 7'h10};
    logic [6:0] pos [4] = '{7'h40, 7'h20, 7'h0c, 7'h02};
    logic       a;
    int         n;
    slp();
    repeat (3) @(posedge clk);
    chk(sleeping, 1'b0);
    adc_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(SPC_ADDR_SLEEP, 8'h20 | 8'(k << 3));
      slp();
      @(negedge clk);
      a = adc_start;
      @(negedge clk);
      a = a | adc_start;
      @(negedge clk);
      chk(a, k < 2);
      chk(gates.core_clock_domain, 1'b0);
      chk(gates.peripheral_io_clock_domain, k == 0);
      chk(gates.main_osc, k != 2);
      chk(gates.program_memory_clock_domain, 1'b0);
      chk(gates.converter_clock_domain, k < 2);
      chk(gates.fast_peripheral_clock_domain, k == 0);
      pulse_wake(neg[k]);
      repeat (4) @(posedge clk);
      chk(sleeping, 1'b1);
      pulse_wake(pos[k]);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (core_resume !== 1'b1 && n < 100);
      chk(n >= SC + 4 && n <= SC + 7, 1);
      repeat (3) @(posedge clk);
      chk(sleeping, 1'b0);
    end
    wr(SPC_ADDR_SLEEP, 8'hff);
    rd(SPC_ADDR_SLEEP);
    chk(d, 8'h38);
    wr(8'h05, 8'hff);
    rd(8'h05);
    chk(d, 8'h00);
    wr(SPC_ADDR_SLEEP, 8'h28);
    slp();
    repeat (3) @(posedge clk);
    chk(sleeping, 1'b1);
    do_reset(1'b0);
    chk(sleeping, 1'b0);
    $display("sleep test done");
  endtask : t_sleep
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    t_fuse();
    t_unlock();
    t_sleep();
    give_verdict();
  end
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : test_sysclk_prescaler_sleep_ctrl
`default_nettype wire
